// >>> hdl/scb_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Auxiliary fault status reads zero, ignores writes
// - Fault status subregisters by byte and halfword
// - Primary field 11 grants full FP access
// - Two restrictive settings raise no-coprocessor fault
// - Field gates FP instructions and registers
// - Secondary FP field has no effect
// - Secondary field readback defined only when matching
// - FP privilege register banked per security state
// - Nonsecure access register is one shared copy
// - Auxiliary control banked per security state
// - One bit gates nonsecure FP access
// - Auxiliary control resets to zero
// - Config control resets to 0x00000201
// - Interrupt/reset control resets to FA050000
// - Memory fault address has no reset
// - Identification register read-only, fixed code
module srb_regs
  import srb_pkg::*;
#(
  parameter bit          HAS_SECURITY = 1'b1,
  // Arbitrary neutral identification value
  parameter logic [31:0] PROC_ID      = 32'h0000_1234
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire srb_bus_req_type bus_req,
  output logic [31:0]          rdata,
  output logic                 access_fault,
  input  wire srb_fp_req_type  fp_req,
  output logic                 fp_grant,
  output logic                 no_coprocessor_fault,
  input  wire srb_fault_type   fault_in
);

  //////////////////////////////////////////////////////////////////////
  // Access decode

  logic        access;
  logic        misaligned;
  logic        refuse;
  logic        wr_ok;
  logic        rd_ok;
  logic [1:0]  lane_off;
  logic [3:0]  lanes;
  logic [31:0] wmask;
  logic [31:0] wdata_sh;
  logic        bank;
  logic [29:0] waddr;

  assign access   = bus_req.rd | bus_req.wr;
  assign lane_off = bus_req.addr[1:0];
  assign waddr    = bus_req.addr[31:2];
  assign bank     = HAS_SECURITY & bus_req.secure;

  always_comb begin
    unique case (bus_req.size)
      SRB_SIZE_BYTE: misaligned = 1'b0;
      SRB_SIZE_HALF: misaligned = lane_off[0];
      SRB_SIZE_WORD: misaligned = |lane_off;
      default:       misaligned = 1'b1;
    endcase
  end

  // Refused accesses leave every register untouched
  assign refuse = access & (~bus_req.priv | misaligned);
  assign wr_ok  = bus_req.wr & ~refuse;
  assign rd_ok  = bus_req.rd & ~refuse;

  always_comb begin
    unique case (bus_req.size)
      SRB_SIZE_BYTE: lanes = 4'h1 << lane_off;
      SRB_SIZE_HALF: lanes = 4'h3 << lane_off;
      default:       lanes = 4'hF;
    endcase
  end

  always_comb begin
    wmask = '0;
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{lanes[i]}};
    end
  end

  // Narrow writes carry their data in the low bits
  assign wdata_sh = bus_req.wdata << {lane_off, 3'b000};

  function automatic logic hit(input logic [31:0] a);
    return waddr == a[31:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~wmask) | (wdata_sh & wmask);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Plain storage registers

  logic [31:0] plain [NUM_PLAIN];

  generate
    for (genvar g = 0; g < NUM_PLAIN; g++) begin : g_plain
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          plain[g] <= PLAIN_RESET[g];
        end else if (wr_ok && hit(PLAIN_ADDR[g])) begin
          plain[g] <= merge(plain[g]);
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Banked auxiliary control and FP privilege

  logic [31:0] aux_ctrl [2];
  logic [1:0]  fp_prim  [2];
  logic [1:0]  fp_sec   [2];
  logic [31:0] fp_word;

  assign fp_word = merge({8'h00, fp_sec[bank], fp_prim[bank], 20'h0});

  generate
    for (genvar b = 0; b < 2; b++) begin : g_bank
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          aux_ctrl[b] <= AUX_CTRL_RESET;
        end else if (wr_ok && hit(ADDR_AUX_CTRL) && bank == b) begin
          aux_ctrl[b] <= merge(aux_ctrl[b]);
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          fp_prim[b] <= FP_RESET;
          fp_sec[b]  <= FP_RESET;
        end else if (wr_ok && hit(ADDR_FP_PRIV) && bank == b) begin
          // Secondary kept as written; mismatch readback is undefined
          fp_prim[b] <= fp_word[FP_PRIM_LSB +: 2];
          fp_sec[b]  <= fp_word[FP_SEC_LSB +: 2];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Shared nonsecure FP access

  logic        ns_prim;
  logic        ns_sec;
  logic [31:0] ns_word;

  assign ns_word = merge({20'h0, ns_sec, ns_prim, 10'h0});

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ns_prim <= NS_FP_RESET;
      ns_sec  <= NS_FP_RESET;
    end else if (wr_ok && hit(ADDR_NS_FP)) begin
      ns_prim <= ns_word[NS_PRIM_BIT];
      ns_sec  <= ns_word[NS_SEC_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Fault status and address

  logic [31:0] fault_stat;
  logic [31:0] hard_stat;
  logic [31:0] mem_addr;
  logic [31:0] bus_addr;

  // Write one clears; a new fault in the same cycle wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault_stat <= FAULT_RESET;
    end else begin
      fault_stat <= (fault_stat
                     & ~((wr_ok && hit(ADDR_FAULT_STAT)) ?
                         (wdata_sh & wmask) : 32'h0000_0000))
                    | fault_in.status_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hard_stat <= FAULT_RESET;
    end else begin
      hard_stat <= (hard_stat
                    & ~((wr_ok && hit(ADDR_HARD_STAT)) ?
                        (wdata_sh & wmask) : 32'h0000_0000))
                   | fault_in.hard_set;
    end
  end

  // Address holders are data only, so no reset is spent on them
  always_ff @(posedge clk) begin
    if (fault_in.mem_addr_valid) begin
      mem_addr <= fault_in.addr;
    end else if (wr_ok && hit(ADDR_MEM_ADDR)) begin
      mem_addr <= merge(mem_addr);
    end
  end

  always_ff @(posedge clk) begin
    if (fault_in.bus_addr_valid) begin
      bus_addr <= fault_in.addr;
    end else if (wr_ok && hit(ADDR_BUS_ADDR)) begin
      bus_addr <= merge(bus_addr);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read path

  logic [31:0] rd_word;
  logic [31:0] rd_shift;
  logic [31:0] next_rdata;

  always_comb begin
    rd_word = 32'h0000_0000;
    for (int i = 0; i < NUM_PLAIN; i++) begin
      if (hit(PLAIN_ADDR[i])) begin
        rd_word = plain[i];
      end
    end
    if (hit(ADDR_PROC_ID))    rd_word = PROC_ID;
    if (hit(ADDR_AUX_CTRL))   rd_word = aux_ctrl[bank];
    if (hit(ADDR_FAULT_STAT)) rd_word = fault_stat;
    if (hit(ADDR_HARD_STAT))  rd_word = hard_stat;
    if (hit(ADDR_MEM_ADDR))   rd_word = mem_addr;
    if (hit(ADDR_BUS_ADDR))   rd_word = bus_addr;
    if (hit(ADDR_FP_PRIV)) begin
      rd_word = {8'h00, fp_sec[bank], fp_prim[bank], 20'h0};
    end
    if (hit(ADDR_NS_FP)) begin
      rd_word = {20'h0, ns_sec, ns_prim, 10'h0};
    end
  end

  assign rd_shift = rd_word >> {lane_off, 3'b000};

  always_comb begin
    unique case (bus_req.size)
      SRB_SIZE_BYTE: next_rdata = {24'h0, rd_shift[7:0]};
      SRB_SIZE_HALF: next_rdata = {16'h0, rd_shift[15:0]};
      default:       next_rdata = rd_shift;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd_ok ? next_rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      access_fault <= 1'b0;
    end else begin
      access_fault <= refuse;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // FP permission check

  logic [1:0] fp_field;
  logic       fp_priv_ok;
  logic       fp_ns_ok;
  logic       fp_allow;

  // Only the primary field is consulted
  assign fp_field = fp_prim[HAS_SECURITY & fp_req.secure];

  always_comb begin
    unique case (fp_field)
      FP_FULL:      fp_priv_ok = 1'b1;
      FP_PRIV_ONLY: fp_priv_ok = fp_req.priv;
      // Reserved encoding treated as deny, the safe side
      default:      fp_priv_ok = 1'b0;
    endcase
  end

  assign fp_ns_ok = ~HAS_SECURITY | fp_req.secure | ns_prim;
  assign fp_allow = fp_priv_ok & fp_ns_ok;

  // One check covers instructions and register D0-D16 access alike
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fp_grant             <= 1'b0;
      no_coprocessor_fault <= 1'b0;
    end else begin
      fp_grant             <= fp_req.valid & fp_allow;
      no_coprocessor_fault <= fp_req.valid & ~fp_allow;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic [NUM_PLAIN-1:0] plain_written;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      plain_written <= '0;
    end else begin
      for (int i = 0; i < NUM_PLAIN; i++) begin
        if (wr_ok && hit(PLAIN_ADDR[i])) plain_written[i] <= 1'b1;
      end
    end
  end

  // Address compared inline: a function's free variables go unsampled
  sequence s_word_rd(logic [31:0] a);
    rd_ok && bus_req.size == SRB_SIZE_WORD && waddr == a[31:2];
  endsequence

  sequence s_fp_ask(logic [1:0] f);
    fp_req.valid && fp_field == f && fp_ns_ok;
  endsequence

  a_aux_fault_raz: assert property (
    s_word_rd(ADDR_AUX_FAULT) |=> rdata == 32'h0000_0000)
    else $error("aux fault status not read as zero");

  a_bus_stat_byte: assert property (
    rd_ok && bus_req.size == SRB_SIZE_BYTE && bus_req.addr == ADDR_BUS_STAT
    |=> rdata == {24'h0, $past(fault_stat[15:8])})
    else $error("bus fault byte read wrong");

  a_fp_full_ok: assert property (
    s_fp_ask(FP_FULL) |=> fp_grant && !no_coprocessor_fault)
    else $error("full access not granted");

  a_fp_deny_all: assert property (
    s_fp_ask(FP_DENY) |=> no_coprocessor_fault && !fp_grant)
    else $error("deny setting granted access");

  a_fp_unpriv: assert property (
    s_fp_ask(FP_PRIV_ONLY) ##0 !fp_req.priv |=> no_coprocessor_fault)
    else $error("unprivileged access not faulted");

  a_ns_fp_deny: assert property (
    fp_req.valid && HAS_SECURITY && !fp_req.secure && !ns_prim
    |=> no_coprocessor_fault)
    else $error("nonsecure access not faulted");

  a_fp_bank_sep: assert property (
    wr_ok && waddr == ADDR_FP_PRIV[31:2] && bank |=> $stable(fp_prim[0]))
    else $error("secure write changed nonsecure bank");

  a_aux_bank_sep: assert property (
    wr_ok && waddr == ADDR_AUX_CTRL[31:2] && !bank |=> $stable(aux_ctrl[1]))
    else $error("nonsecure write changed secure bank");

  a_cfg_ctrl_init: assert property (
    s_word_rd(PLAIN_ADDR[IDX_CFG_CTRL]) ##0 !plain_written[IDX_CFG_CTRL]
    |=> rdata == 32'h0000_0201)
    else $error("config control reset value wrong");

  a_rst_ctrl_init: assert property (
    s_word_rd(PLAIN_ADDR[IDX_APP_RST]) ##0 !plain_written[IDX_APP_RST]
    |=> rdata == 32'hFA05_0000)
    else $error("interrupt reset control value wrong");

  a_proc_id_ro: assert property (
    s_word_rd(ADDR_PROC_ID) |=> rdata == PROC_ID)
    else $error("identification value changed");

  a_unpriv_refuse: assert property (
    access && !bus_req.priv |=> access_fault && rdata == 32'h0000_0000)
    else $error("unprivileged access not refused");

  a_fault_set_wins: assert property (
    |fault_in.status_set
    |=> &(fault_stat | ~$past(fault_in.status_set)))
    else $error("fault event lost against clear");

endmodule // srb_regs

// >>> hdl/scb_pkg.sv
package srb_pkg;

  typedef enum logic [1:0] {
    SRB_SIZE_BYTE,
    SRB_SIZE_HALF,
    SRB_SIZE_WORD
  } srb_size_type;

  typedef struct packed {
    logic         rd;
    logic         wr;
    logic         priv;
    logic         secure;
    srb_size_type size;
    logic [31:0]  addr;
    logic [31:0]  wdata;
  } srb_bus_req_type;

  typedef struct packed {
    logic valid;
    logic priv;
    logic secure;
  } srb_fp_req_type;

  typedef struct packed {
    logic [31:0] status_set;
    logic [31:0] hard_set;
    logic        mem_addr_valid;
    logic        bus_addr_valid;
    logic [31:0] addr;
  } srb_fault_type;

  localparam logic [31:0] ADDR_AUX_CTRL   = 32'hE000_E008;
  localparam logic [31:0] ADDR_PROC_ID    = 32'hE000_ED00;
  localparam logic [31:0] ADDR_FAULT_STAT = 32'hE000_ED28;
  localparam logic [31:0] ADDR_MEM_STAT   = 32'hE000_ED28;
  localparam logic [31:0] ADDR_BUS_STAT   = 32'hE000_ED29;
  localparam logic [31:0] ADDR_USE_STAT   = 32'hE000_ED2A;
  localparam logic [31:0] ADDR_HARD_STAT  = 32'hE000_ED2C;
  localparam logic [31:0] ADDR_MEM_ADDR   = 32'hE000_ED34;
  localparam logic [31:0] ADDR_BUS_ADDR   = 32'hE000_ED38;
  localparam logic [31:0] ADDR_AUX_FAULT  = 32'hE000_ED3C;
  localparam logic [31:0] ADDR_FP_PRIV    = 32'hE000_ED88;
  localparam logic [31:0] ADDR_NS_FP      = 32'hE000_ED8C;

  localparam int NUM_PLAIN    = 9;
  localparam int IDX_APP_RST  = 3;
  localparam int IDX_CFG_CTRL = 5;
  localparam logic [31:0] PLAIN_ADDR [NUM_PLAIN] = '{
    32'hE000_ED04, 32'hE000_ED08, 32'hE000_ED10, 32'hE000_ED0C,
    32'hE000_ED20, 32'hE000_ED14, 32'hE000_ED18, 32'hE000_ED1C,
    32'hE000_ED24};
  localparam logic [31:0] PLAIN_RESET [NUM_PLAIN] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hFA05_0000,
    32'h0000_0000, 32'h0000_0201, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000};

  localparam logic [31:0] AUX_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FAULT_RESET    = 32'h0000_0000;
  localparam logic [1:0]  FP_RESET       = 2'h0;
  localparam logic        NS_FP_RESET    = 1'b0;

  localparam int FP_PRIM_LSB = 20;
  localparam int FP_SEC_LSB  = 22;
  localparam int NS_PRIM_BIT = 10;
  localparam int NS_SEC_BIT  = 11;

  localparam logic [1:0] FP_DENY      = 2'h0;
  localparam logic [1:0] FP_PRIV_ONLY = 2'h1;
  localparam logic [1:0] FP_FULL      = 2'h3;

endpackage

// >>> dv/scb_regs_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin checks_done++; if ((gt) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module srb_regs_tb;
  import srb_pkg::*;
  localparam logic [31:0] TB_PROC_ID    = 32'h0000_1234; // Arbitrary value
  localparam logic [31:0] ADDR_CFG_CTRL = 32'hE000_ED14;
  localparam logic [31:0] ADDR_VEC_BASE = 32'hE000_ED08;

  logic            clk;
  logic            reset_n;
  srb_bus_req_type bus_req;
  logic [31:0]     rdata;
  logic            access_fault;
  srb_fp_req_type  fp_req;
  logic            fp_grant;
  logic            no_coprocessor_fault;
  srb_fault_type   fault_in;
  int              num_errors;
  int              checks_done;
  int              cycles;

  srb_regs #(
    .HAS_SECURITY (1'b1),
    .PROC_ID      (TB_PROC_ID)
  ) srb_regs_inst (
    .clk                  (clk),
    .reset_n              (reset_n),
    .bus_req              (bus_req),
    .rdata                (rdata),
    .access_fault         (access_fault),
    .fp_req               (fp_req),
    .fp_grant             (fp_grant),
    .no_coprocessor_fault (no_coprocessor_fault),
    .fault_in             (fault_in)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One bus cycle; answer sampled after the edge that took the strobe
  task automatic bus(input logic r, input logic w, input logic [31:0] a,
                     input logic [31:0] wd, input logic p, input logic s,
                     input srb_size_type z, output logic [31:0] d,
                     output logic f);
    @(posedge clk);
    bus_req <= '{rd: r, wr: w, priv: p, secure: s, size: z, addr: a,
                 wdata: wd};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    bus_req.wr <= 1'b0;
    #1;
    d = rdata;
    f = access_fault;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd,
                    input logic p = 1'b1, input logic s = 1'b1,
                    input srb_size_type z = SRB_SIZE_WORD,
                    input logic ef = 1'b0);
    logic [31:0] d;
    logic        f;
    bus(1'b0, 1'b1, a, wd, p, s, z, d, f);
    `CHK("write fault", ef, f)
  endtask

  task automatic rdc(input string nm, input logic [31:0] a,
                     input logic [31:0] ex, input logic p = 1'b1,
                     input logic s = 1'b1,
                     input srb_size_type z = SRB_SIZE_WORD,
                     input logic ef = 1'b0);
    logic [31:0] d;
    logic        f;
    bus(1'b1, 1'b0, a, 32'h0000_0000, p, s, z, d, f);
    `CHK(nm, ex, d)
    `CHK("read fault", ef, f)
  endtask

  // Permission request; exactly one of grant or fault follows
  task automatic fpc(input logic p, input logic s, input logic ex);
    @(posedge clk);
    fp_req <= '{valid: 1'b1, priv: p, secure: s};
    @(posedge clk);
    fp_req.valid <= 1'b0;
    #1;
    `CHK("fp grant", ex, fp_grant)
    `CHK("fp fault", ~ex, no_coprocessor_fault)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values();
    for (int i = 0; i < NUM_PLAIN; i++) begin
      rdc("plain reset", PLAIN_ADDR[i], PLAIN_RESET[i]);
    end
    rdc("aux ctrl", ADDR_AUX_CTRL, 32'h0000_0000);
    rdc("proc id", ADDR_PROC_ID, TB_PROC_ID);
    $display("test reset_values done");
  endtask

  task automatic test_read_only();
    wr(ADDR_PROC_ID, 32'hFFFF_FFFF);
    rdc("proc id kept", ADDR_PROC_ID, TB_PROC_ID);
    wr(ADDR_AUX_FAULT, 32'hFFFF_FFFF);
    rdc("aux fault", ADDR_AUX_FAULT, 32'h0000_0000);
    $display("test read_only done");
  endtask

  task automatic test_privilege();
    rdc("unpriv read", ADDR_CFG_CTRL, 32'h0000_0000, 1'b0, 1'b1,
        SRB_SIZE_WORD, 1'b1);
    wr(ADDR_CFG_CTRL, 32'h0000_0000, 1'b0, 1'b1, SRB_SIZE_WORD,
       1'b1);
    rdc("cfg kept", ADDR_CFG_CTRL, 32'h0000_0201);
    wr(ADDR_VEC_BASE, 32'h0000_4F00);
    rdc("vector base", ADDR_VEC_BASE, 32'h0000_4F00);
    $display("test privilege done");
  endtask

  task automatic test_fault_status();
    @(posedge clk);
    fault_in.status_set     <= 32'h1234_5681;
    fault_in.mem_addr_valid <= 1'b1;
    fault_in.addr           <= 32'h2000_0040;
    @(posedge clk);
    fault_in.status_set     <= 32'h0000_0000;
    fault_in.mem_addr_valid <= 1'b0;
    rdc("fault word", ADDR_FAULT_STAT, 32'h1234_5681);
    rdc("mem byte", ADDR_MEM_STAT, 32'h0000_0081, 1'b1, 1'b1,
        SRB_SIZE_BYTE);
    rdc("bus byte", ADDR_BUS_STAT, 32'h0000_0056, 1'b1, 1'b1,
        SRB_SIZE_BYTE);
    rdc("use half", ADDR_USE_STAT, 32'h0000_1234, 1'b1, 1'b1,
        SRB_SIZE_HALF);
    wr(ADDR_BUS_STAT, 32'h0000_0056, 1'b1, 1'b1, SRB_SIZE_BYTE);
    rdc("after clear", ADDR_FAULT_STAT, 32'h1234_0081);
    // Clear of bits 1:0 meets a new event on bit 1; the event wins
    fork
      wr(ADDR_FAULT_STAT, 32'h0000_0003);
      begin
        @(posedge clk);
        fault_in.status_set <= 32'h0000_0002;
        @(posedge clk);
        fault_in.status_set <= 32'h0000_0000;
      end
    join
    rdc("set wins", ADDR_FAULT_STAT, 32'h1234_0082);
    rdc("mem addr", ADDR_MEM_ADDR, 32'h2000_0040);
    $display("test fault_status done");
  endtask

  task automatic test_fp_privilege();
    logic [1:0] enc [3] = '{FP_DENY, FP_PRIV_ONLY, FP_FULL};
    for (int i = 0; i < 3; i++) begin
      // Secondary field deliberately differs from the primary one
      wr(ADDR_FP_PRIV, {8'h00, ~enc[i], enc[i], 20'h0_0000});
      fpc(1'b1, 1'b1, enc[i] != FP_DENY);
      fpc(1'b0, 1'b1, enc[i] == FP_FULL);
    end
    wr(ADDR_FP_PRIV, 32'h0030_0000, 1'b1, 1'b0);
    fpc(1'b1, 1'b0, 1'b0);
    wr(ADDR_NS_FP, 32'h0000_0C00);
    fpc(1'b1, 1'b0, 1'b1);
    rdc("ns shared", ADDR_NS_FP, 32'h0000_0C00, 1'b1, 1'b0);
    rdc("fp ns bank", ADDR_FP_PRIV, 32'h0030_0000, 1'b1, 1'b0);
    rdc("fp s bank", ADDR_FP_PRIV, 32'h0030_0000);
    wr(ADDR_FP_PRIV, 32'h0000_0000, 1'b1, 1'b0);
    fpc(1'b1, 1'b0, 1'b0);
    fpc(1'b1, 1'b1, 1'b1);
    $display("test fp_privilege done");
  endtask

  task automatic test_aux_banked();
    wr(ADDR_AUX_CTRL, 32'h0000_0205);
    rdc("aux ns", ADDR_AUX_CTRL, 32'h0000_0000, 1'b1, 1'b0);
    rdc("aux s", ADDR_AUX_CTRL, 32'h0000_0205);
    $display("test aux_banked done");
  endtask

  task automatic test_hard_fault();
    @(posedge clk);
    fault_in.hard_set       <= 32'h4000_0002;
    fault_in.bus_addr_valid <= 1'b1;
    fault_in.addr           <= 32'h4001_0008;
    @(posedge clk);
    fault_in.hard_set       <= 32'h0000_0000;
    fault_in.bus_addr_valid <= 1'b0;
    rdc("hard stat", ADDR_HARD_STAT, 32'h4000_0002);
    rdc("bus addr", ADDR_BUS_ADDR, 32'h4001_0008);
    wr(ADDR_HARD_STAT, 32'h4000_0000);
    rdc("hard clear", ADDR_HARD_STAT, 32'h0000_0002);
    $display("test hard_fault done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("CHECK FAILED timeout expected done seen hang");
      print_verdict();
    end
  end

  initial begin
    num_errors  = 0;
    checks_done = 0;
    cycles      = 0;
    reset_n     = 1'b0;
    bus_req     = '0;
    fp_req      = '0;
    fault_in    = '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    test_reset_values();
    test_read_only();
    test_privilege();
    test_fault_status();
    test_fp_privilege();
    test_aux_banked();
    test_hard_fault();
    print_verdict();
  end
endmodule // srb_regs_tb
